// ### gfm_pkg.sv
// gfm_pkg: constants and carrier types of the fault manager;
// assumes a 200 MHz clock and 32-bit Wishbone.
// Operation
// RULE1 - supply undervoltage: gates Hi-Z, pump and logic off, fault low, flags set
// RULE2 - supply recovery automatic; supply flag sticks until a clear
// RULE3 - pump undervoltage: gates Hi-Z, fault low, flags set, logic runs
// RULE4 - pump recovery automatic; pump flag sticks until a clear
// RULE5 - pump undervoltage disable bit set: pump undervoltage ignored
// RULE6 - pin variant: pump protection always on
// RULE7 - drain-source event: enabled MOSFET over threshold past deglitch
// RULE8 - pin variant: 4 us deglitch, 4 ms retry, off with pin at rail
// RULE9 - serial variant: threshold, deglitch from fields; four response modes
// RULE10 - latched mode: shut gates, fault low, flags; resume after clear, cause gone
// RULE11 - latched or retry shutdown uses reduced gate current
// RULE12 - retry mode: shut gates, fault low, flags; resume after retry interval
// RULE13 - retry mode: overcurrent flags held for the whole retry interval
// RULE14 - report mode only pulls fault low; disabled mode does nothing
// RULE15 - shunt: same responses; ignored in mode 11b or when disabled
// RULE16 - gate stuck: Hi-Z, fault low, latched until clear; ignored when disabled
// RULE17 - thermal warning keeps gates on; optional report withdraws by itself
// RULE18 - thermal shutdown: gates Hi-Z, fault low, automatic recovery
// RULE19 - thermal shutdown flag sticks until a clear
// RULE20 - thermal warning flag clears by itself
// RULE21 - fault low when any monitor reports; Hi-Z on any shutdown fault
package gfm_pkg;

    // clock and timing
    localparam int CLK_MHZ       = 200;
    localparam int RETRY_TIME_US = 4000;                   // 4 ms retry interval
    localparam int RETRY_CYC     = RETRY_TIME_US * CLK_MHZ;
    localparam int DEG_BASE_NS   = 1000;                   // serial deglitch step, sel 0
    localparam int DEG_BASE_CYC  = (DEG_BASE_NS * CLK_MHZ + 999) / 1000;
    localparam int DEG_PIN_NS    = 4000;                   // fixed pin-variant deglitch
    localparam int DEG_PIN_CYC   = (DEG_PIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DEG_W         = 12;
    localparam int RETRY_W       = 20;
    localparam int NUM_FET       = 6;
    localparam int NUM_OC        = NUM_FET + 1;            // six drain-source plus shunt

    // register byte offsets
    localparam logic [7:0] ADR_STATUS  = 8'h00;
    localparam logic [7:0] ADR_CONTROL = 8'h04;

    // control register fields
    localparam int CTL_CLEAR     = 0;
    localparam int CTL_MODE_LO   = 1;
    localparam int CTL_PUMP_DIS  = 3;
    localparam int CTL_SHUNT_DIS = 4;
    localparam int CTL_GATE_DIS  = 5;
    localparam int CTL_TW_REP    = 6;
    localparam int CTL_DEG_LO    = 8;
    localparam int CTL_VDS_LO    = 12;
    localparam int CTL_CUR_LO    = 16;
    localparam logic [31:0] CTL_WMASK = 32'h000FF37E;
    localparam logic [31:0] CTL_RESET = 32'h000F0200;      // latched, 4 us, full current

    // status register fields
    localparam int ST_FAULT   = 0;
    localparam int ST_SUPPLY  = 1;
    localparam int ST_PUMP    = 2;
    localparam int ST_VDS     = 3;
    localparam int ST_SHUNT   = 4;
    localparam int ST_GATE    = 5;
    localparam int ST_TWARN   = 6;
    localparam int ST_TSD     = 7;
    localparam int ST_PIN     = 8;
    localparam int ST_VDS_LO  = 16;
    localparam int ST_GATE_LO = 24;

    localparam logic [3:0] REDUCED_CURRENT = 4'h0;         // slow turn-off drive code

    typedef enum logic [1:0] {
        MODE_LATCH  = 2'h0,
        MODE_RETRY  = 2'h1,
        MODE_REPORT = 2'h2,
        MODE_OFF    = 2'h3
    } gfm_mode_e;

    typedef enum logic [1:0] {
        OC_IDLE   = 2'h0,
        OC_RETRY  = 2'h1,
        OC_LATCH  = 2'h3,
        OC_REPORT = 2'h2
    } gfm_oc_state_e;

    // asynchronous monitor and pin levels
    typedef struct packed {
        logic               supply_uv;
        logic               pump_uv;
        logic [NUM_FET-1:0] vds_over;
        logic               shunt_over;
        logic [NUM_FET-1:0] gate_stuck;
        logic               thermal_warn;
        logic               thermal_sd;
        logic               vds_pin_rail;
        logic               enable_rst;
        logic               fault_pin;
    } gfm_mon_s;

endpackage

// ### gfm_fault_manager.sv
// gfm_fault_manager: fault supervision, gate and fault-pin response, Wishbone slave;
// monitors are asynchronous levels,
// mosfet_en_i comes from same-clock gate logic.
`timescale 1ns/10ps
`default_nettype none
module gfm_fault_manager #(
    parameter int RETRY_CYCLES = gfm_pkg::RETRY_CYC,
    parameter bit SERIAL_PORT  = 1'b1
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // classic wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // monitors and pins
    input  wire gfm_pkg::gfm_mon_s         mon_i,
    input  wire logic [gfm_pkg::NUM_FET-1:0] mosfet_en_i,
    input  wire logic                      fault_out_n_i,
    output logic                           fault_out_n_o,
    output logic                           fault_out_n_oe_o,
    // gate-driver controls
    output logic                           gate_hiz_o,
    output logic                           pump_disable_o,
    output logic                           logic_disable_o,
    output logic                           reduced_drive_o,
    output logic      [3:0]                gate_current_o,
    output logic      [3:0]                drain_source_threshold_sel_o
);
    import gfm_pkg::*;

    // two-flop synchroniser
    gfm_mon_s mon_meta_reg;
    gfm_mon_s mon_reg;
    logic     enable_rst_d_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mon_meta_reg     <= '0;
            mon_reg          <= '0;
            enable_rst_d_reg <= 1'b0;
        end else begin
            mon_meta_reg     <= mon_i;
            mon_reg          <= mon_meta_reg;
            enable_rst_d_reg <= mon_reg.enable_rst;
        end
    end

    // wishbone request decode
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] ctrl_reg;
    wire         wb_req     = wb_cyc_i & wb_stb_i;
    wire         hit_status = (wb_adr_i == ADR_STATUS);
    wire         hit_ctrl   = (wb_adr_i == ADR_CONTROL);
    wire         wr_commit  = wb_req & wb_we_i & ack_reg;   // at the edge the master sees ack
    wire [31:0]  sel_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0]  wr_mask    = sel_mask & CTL_WMASK;
    wire [31:0]  ctrl_next  = (ctrl_reg & ~wr_mask) | (wb_dat_i & wr_mask);

    // clear: command bit or enable reset pulse edge
    wire clear_cmd  = wr_commit & hit_ctrl & wb_sel_i[0] & wb_dat_i[CTL_CLEAR];
    wire enable_rst = mon_reg.enable_rst & ~enable_rst_d_reg;
    wire fault_clear_cmd = clear_cmd | enable_rst;

    // configuration fields; the pin variant uses fixed values, except the gate current and the drain-source threshold select
    wire [1:0] mode_field    = ctrl_reg[CTL_MODE_LO +: 2];
    wire [1:0] deglitch_sel  = ctrl_reg[CTL_DEG_LO +: 2];
    wire [1:0] overcurrent_response_mode      = SERIAL_PORT ? mode_field : MODE_RETRY; // [RULE8] [RULE9]
    wire       pump_uv_disable = SERIAL_PORT & ctrl_reg[CTL_PUMP_DIS]; // [RULE6]
    wire       shunt_oc_disable = SERIAL_PORT & ctrl_reg[CTL_SHUNT_DIS];
    wire       gate_stuck_disable = SERIAL_PORT & ctrl_reg[CTL_GATE_DIS];
    wire       thermal_warning_report_en = SERIAL_PORT & ctrl_reg[CTL_TW_REP];
    wire [3:0] gate_current_setting = ctrl_reg[CTL_CUR_LO +: 4];
    wire [DEG_W-1:0] deg_serial = DEG_W'(DEG_BASE_CYC) << deglitch_sel;
    wire [DEG_W-1:0] deg_limit  = SERIAL_PORT ? deg_serial : DEG_W'(DEG_PIN_CYC); // [RULE8] [RULE9]

    // overcurrent sources gated by mode, disable bit, strap
    wire mode_off     = (overcurrent_response_mode == MODE_OFF); // [RULE14]
    wire vds_enable   = ~mode_off & (SERIAL_PORT | ~mon_reg.vds_pin_rail); // [RULE8]
    wire shunt_enable = ~mode_off & ~shunt_oc_disable; // [RULE15]

    // per-source condition; drain-source only for an enabled fet
    logic [NUM_OC-1:0] oc_cond;
    logic [NUM_OC-1:0] oc_hit;
    logic [DEG_W-1:0]  deg_cnt_reg [NUM_OC];

    assign oc_cond[NUM_FET-1:0] = mon_reg.vds_over & mosfet_en_i & {NUM_FET{vds_enable}}; // [RULE7]
    assign oc_cond[NUM_FET]     = mon_reg.shunt_over & shunt_enable; // [RULE15]

    // deglitch: event once the condition outlasts the limit
    for (genvar i = 0; i < NUM_OC; i++) begin : g_deg
        always_ff @(posedge clk_i) begin
            if (rst_i || !oc_cond[i]) begin
                deg_cnt_reg[i] <= '0;
            end else if (deg_cnt_reg[i] != deg_limit) begin
                deg_cnt_reg[i] <= deg_cnt_reg[i] + DEG_W'(1);
            end
        end
        assign oc_hit[i] = oc_cond[i] & (deg_cnt_reg[i] == deg_limit); // [RULE7]
    end

    wire oc_event   = |oc_hit;
    wire oc_present = |oc_cond;

    // overcurrent response state machine
    gfm_oc_state_e     oc_state_reg;
    gfm_oc_state_e     oc_state_next;
    logic [RETRY_W-1:0] retry_cnt_reg;
    wire retry_done = (retry_cnt_reg == RETRY_W'(RETRY_CYCLES - 1));

    always_comb begin
        oc_state_next = oc_state_reg;
        case (oc_state_reg)
            OC_IDLE: begin
                if (oc_event) begin
                    case (overcurrent_response_mode)
                        MODE_LATCH:  oc_state_next = OC_LATCH;  // [RULE10]
                        MODE_RETRY:  oc_state_next = OC_RETRY;  // [RULE12]
                        MODE_REPORT: oc_state_next = OC_REPORT; // [RULE14]
                        default:     oc_state_next = OC_IDLE;
                    endcase
                end
            end
            OC_LATCH, OC_REPORT: begin
                if (fault_clear_cmd && !oc_present) begin
                    oc_state_next = OC_IDLE; // [RULE10]
                end
            end
            OC_RETRY: begin
                if (retry_done) begin
                    oc_state_next = OC_IDLE; // [RULE12]
                end
            end
            default: oc_state_next = OC_IDLE;
        endcase
    end

    // state and retry interval counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_state_reg  <= OC_IDLE;
            retry_cnt_reg <= '0;
        end else begin
            oc_state_reg  <= oc_state_next;
            retry_cnt_reg <= (oc_state_reg == OC_RETRY && !retry_done) ?
                             retry_cnt_reg + RETRY_W'(1) : '0;
        end
    end

    // oc flags clear at retry expiry, or on clear once the cause is gone
    wire oc_flag_clr = (oc_state_reg == OC_RETRY) ? retry_done : // [RULE13]
                       (fault_clear_cmd & ~oc_present);
    wire oc_shutdown = (oc_state_reg == OC_LATCH) | (oc_state_reg == OC_RETRY);

    // monitor conditions that stand at this moment
    wire supply_uv_active = mon_reg.supply_uv; // [RULE1]
    wire pump_uv_active   = mon_reg.pump_uv & ~pump_uv_disable; // [RULE3] [RULE5]
    wire [NUM_FET-1:0] gate_stuck_cond =
        mon_reg.gate_stuck & {NUM_FET{~gate_stuck_disable}}; // [RULE16]
    wire thermal_sd_active = mon_reg.thermal_sd; // [RULE18]

    // sticky flags, thermal warning follows its monitor; a set in the cycle of a clear wins
    logic               supply_undervolt_flag_reg;
    logic               pump_undervolt_flag_reg;
    logic [NUM_FET-1:0] drain_source_overcurrent_flag_reg;
    logic               shunt_overcurrent_flag_reg;
    logic [NUM_FET-1:0] gate_stuck_fault_reg;
    logic               thermal_shutdown_flag_reg;
    logic               thermal_warning_reg;
    wire                gate_clr = fault_clear_cmd & ~(|gate_stuck_cond);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            supply_undervolt_flag_reg         <= 1'b0;
            pump_undervolt_flag_reg           <= 1'b0;
            drain_source_overcurrent_flag_reg <= '0;
            shunt_overcurrent_flag_reg        <= 1'b0;
            gate_stuck_fault_reg              <= '0;
            thermal_shutdown_flag_reg         <= 1'b0;
            thermal_warning_reg               <= 1'b0;
        end else begin
            supply_undervolt_flag_reg <= supply_uv_active |
                                         (supply_undervolt_flag_reg & ~fault_clear_cmd); // [RULE2]
            pump_undervolt_flag_reg   <= pump_uv_active |
                                         (pump_undervolt_flag_reg & ~fault_clear_cmd); // [RULE4]
            drain_source_overcurrent_flag_reg <= oc_hit[NUM_FET-1:0] |
                (drain_source_overcurrent_flag_reg & ~{NUM_FET{oc_flag_clr}}); // [RULE10] [RULE13]
            shunt_overcurrent_flag_reg <= oc_hit[NUM_FET] |
                                          (shunt_overcurrent_flag_reg & ~oc_flag_clr); // [RULE15]
            gate_stuck_fault_reg <= gate_stuck_cond |
                                    (gate_stuck_fault_reg & ~{NUM_FET{gate_clr}}); // [RULE16]
            thermal_shutdown_flag_reg <= thermal_sd_active |
                                         (thermal_shutdown_flag_reg & ~fault_clear_cmd); // [RULE19]
            thermal_warning_reg <= mon_reg.thermal_warn; // [RULE20]
        end
    end

    wire drain_source_any = |drain_source_overcurrent_flag_reg;
    wire gate_stuck_any   = |gate_stuck_fault_reg;
    wire global_fault = supply_undervolt_flag_reg | pump_undervolt_flag_reg |
                        drain_source_any | shunt_overcurrent_flag_reg |
                        gate_stuck_any | thermal_shutdown_flag_reg;

    // combined response: report on the pin, shut the gates
    wire tw_report = thermal_warning_reg & thermal_warning_report_en; // [RULE17]
    wire fault_report = supply_uv_active | pump_uv_active |
                        (oc_state_reg != OC_IDLE) | gate_stuck_any |
                        tw_report | thermal_sd_active; // [RULE21]
    wire hiz_demand = supply_uv_active | pump_uv_active | oc_shutdown |
                      gate_stuck_any | thermal_sd_active; // [RULE21] [RULE17]
    wire pump_off   = supply_uv_active | thermal_sd_active; // [RULE1]

    // registered pin and driver controls
    logic       fault_oe_reg;
    logic       hiz_reg;
    logic       pump_off_reg;
    logic       logic_off_reg;
    logic       reduced_reg;
    logic [3:0] current_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_oe_reg  <= 1'b0;
            hiz_reg       <= 1'b1;
            pump_off_reg  <= 1'b0;
            logic_off_reg <= 1'b0;
            reduced_reg   <= 1'b0;
            current_reg   <= REDUCED_CURRENT;
        end else begin
            fault_oe_reg  <= fault_report; // [RULE21]
            hiz_reg       <= hiz_demand; // [RULE18]
            pump_off_reg  <= pump_off; // [RULE1]
            logic_off_reg <= supply_uv_active; // [RULE1]
            reduced_reg   <= oc_shutdown; // [RULE11]
            current_reg   <= oc_shutdown ? REDUCED_CURRENT : gate_current_setting; // [RULE11]
        end
    end

    assign fault_out_n_o    = 1'b0;    // open drain: only ever pulls low
    assign fault_out_n_oe_o = fault_oe_reg;
    assign gate_hiz_o       = hiz_reg;
    assign pump_disable_o   = pump_off_reg;
    assign logic_disable_o  = logic_off_reg;
    assign reduced_drive_o  = reduced_reg;
    assign gate_current_o   = current_reg;

    // status word assembly
    logic [31:0] status_word;
    always_comb begin
        status_word                              = '0;
        status_word[ST_FAULT]                    = global_fault;
        status_word[ST_SUPPLY]                   = supply_undervolt_flag_reg;
        status_word[ST_PUMP]                     = pump_undervolt_flag_reg;
        status_word[ST_VDS]                      = drain_source_any;
        status_word[ST_SHUNT]                    = shunt_overcurrent_flag_reg;
        status_word[ST_GATE]                     = gate_stuck_any;
        status_word[ST_TWARN]                    = thermal_warning_reg;
        status_word[ST_TSD]                      = thermal_shutdown_flag_reg;
        status_word[ST_PIN]                      = mon_reg.fault_pin;
        status_word[ST_VDS_LO +: NUM_FET]        = drain_source_overcurrent_flag_reg;
        status_word[ST_GATE_LO +: NUM_FET]       = gate_stuck_fault_reg;
    end

    wire [31:0] read_mux = hit_status ? status_word :
                           hit_ctrl   ? ctrl_reg    : 32'h00000000;

    // bus slave: ack one cycle after the request, drop it the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
            ctrl_reg  <= CTL_RESET;
        end else begin
            ack_reg   <= wb_req & ~ack_reg;
            rdata_reg <= (wb_req & ~ack_reg) ? read_mux : rdata_reg;
            if (wr_commit && hit_ctrl) begin
                ctrl_reg <= ctrl_next;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign drain_source_threshold_sel_o = ctrl_reg[CTL_VDS_LO +: 4]; // [RULE9]

    // pin level is read via mon_i.fault_pin instead
    wire unused_pin = fault_out_n_i;

endmodule
`default_nettype wire

// ### gfm_ctrl_model.sv
// gfm_ctrl_model: controller model, a classic Wishbone master;
// expects the device to ack.
`timescale 1ns/10ps
`default_nettype none
module gfm_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      dat_o
);
    // idle bus from time zero
    initial begin
        cyc_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        dat_o = 32'h0;
    end

    // one single cycle: request held until ack is sampled or 20 edges pass, then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk_i);
            ok = (ack_i === 1'b1);
        end
        q = dat_i;
        cyc_o <= 1'b0;
        // at least one idle cycle between requests
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### gfm_fault_manager_checker.sv
// gfm_fault_manager_checker: port-level assertions;
// bound to every fault manager instance, one clock.
`timescale 1ns/10ps
`default_nettype none
module gfm_fault_manager_checker
    import gfm_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter bit SERIAL_PORT  = 1'b1
) (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire gfm_pkg::gfm_mon_s mon_i,
    input wire logic            fault_out_n_oe_o,
    input wire logic            gate_hiz_o,
    input wire logic            pump_disable_o,
    input wire logic            logic_disable_o,
    input wire logic            reduced_drive_o,
    input wire logic [3:0]      gate_current_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request the slave has not answered yet
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_hole;
        s_req ##0 (!wb_we_i && wb_adr_i != ADR_STATUS && wb_adr_i != ADR_CONTROL);
    endsequence
    sequence s_rd_status;
        s_req ##0 (!wb_we_i && wb_adr_i == ADR_STATUS);
    endsequence
    // bus answer timing and read-back values
    chk_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_hole_zero: assert property (s_rd_hole |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_status_resv: assert property (s_rd_status |=> (wb_dat_o & 32'hC0C0FE00) == 32'h0)
        else $error("reserved status bits not zero");
    // shutdown responses
    chk_supply_off: assert property (
        mon_i.supply_uv [*4] |-> gate_hiz_o && fault_out_n_oe_o && logic_disable_o
                                 && pump_disable_o)
        else $error("supply undervoltage response missing");
    chk_tsd_off: assert property (mon_i.thermal_sd [*4] |-> gate_hiz_o && fault_out_n_oe_o)
        else $error("thermal shutdown response missing");
    chk_reduced_drive: assert property (
        reduced_drive_o |-> gate_hiz_o && gate_current_o == REDUCED_CURRENT)
        else $error("reduced drive without shutdown or wrong code");
    chk_hiz_reports: assert property ($rose(gate_hiz_o) |-> fault_out_n_oe_o)
        else $error("gates Hi-Z without fault report");
endmodule
bind gfm_fault_manager gfm_fault_manager_checker #(
    .RETRY_CYCLES(RETRY_CYCLES), .SERIAL_PORT(SERIAL_PORT)
) chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .mon_i, .fault_out_n_oe_o, .gate_hiz_o, .pump_disable_o, .logic_disable_o,
    .reduced_drive_o, .gate_current_o);
`default_nettype wire

// ### testbench.sv
// testbench: self-checks the fault manager through a controller model;
// monitor levels driven directly, short retry interval.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import gfm_pkg::*;
    localparam int RC = 50;
    logic        clk_i, rst_i, cyc, we, ack, oe, hiz, pdis, ldis, red, fo;
    logic [7:0]  adr;
    logic [31:0] wd, rdat, q, ctl;
    logic [3:0]  cur, vsel;
    logic [5:0]  fen;
    gfm_mon_s    mon;
    int          n_mismatch = 0, tests_run = 0, seed = 68, k, m, s, f;
    gfm_ctrl_model host (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
        .adr_o(adr), .dat_o(wd));
    gfm_fault_manager #(.RETRY_CYCLES(RC)) uut (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
        .wb_dat_o(rdat), .wb_ack_o(ack), .mon_i(mon), .mosfet_en_i(fen),
        .fault_out_n_i(1'b1), .fault_out_n_o(fo), .fault_out_n_oe_o(oe), .gate_hiz_o(hiz),
        .pump_disable_o(pdis), .logic_disable_o(ldis), .reduced_drive_o(red),
        .gate_current_o(cur), .drain_source_threshold_sel_o(vsel));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic finish_test(input bit hung);
        if (hung) n_mismatch++;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit ok;
        host.xfer(w, a, d, q, ok);
        if (!ok) finish_test(1'b1);
    endtask
    task automatic wait_oe(input logic e, input int lim);
        for (int n = 0; n < lim && oe !== e; n++) @(posedge clk_i);
        if (oe !== e) finish_test(1'b1);
    endtask
    // expected status word
    function automatic logic [31:0] exp_st(input logic [31:0] fl);
        exp_st = fl | 32'h100;
        exp_st[ST_FAULT] = |(fl & ~32'h40);
    endfunction
    task automatic set_auto(input int i, input logic v);
        @(posedge clk_i);
        case (i)
            0: mon.supply_uv <= v;
            1: mon.pump_uv <= v;
            default: mon.thermal_sd <= v;
        endcase
    endtask
    task automatic clear_and_check();
        bus(1'b1, ADR_CONTROL, ctl | 32'h1);
        wait_oe(1'b0, 8);
        bus(1'b0, ADR_STATUS, 32'h0);
        cmp(q, exp_st(32'h0));
    endtask
    initial begin
        rst_i = 1'b1;
        mon = '0;
        mon.fault_pin = 1'b1;
        fen = '1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        ctl = CTL_RESET;
        bus(1'b0, ADR_CONTROL, 32'h0);
        cmp(q, CTL_RESET);
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0);
        cmp(q, 32'h0);
        bus(1'b0, ADR_CONTROL, 32'h0);
        cmp(q, CTL_RESET);
        // self-recovering faults: supply, pump, thermal shutdown
        for (k = 0; k < 3; k++) begin
            s = (k == 0) ? ST_SUPPLY : (k == 1) ? ST_PUMP : ST_TSD;
            set_auto(k, 1'b1);
            wait_oe(1'b1, 8);
            cmp({hiz, ldis, fo}, {1'b1, k == 0, 1'b0});
            if (k != 1) cmp(pdis, 1'b1);
            set_auto(k, 1'b0);
            wait_oe(1'b0, 8);
            cmp(hiz, 1'b0);
            bus(1'b0, ADR_STATUS, 32'h0);
            cmp(q, exp_st(32'h1 << s));
            if (k == 2) begin
                mon.enable_rst <= 1'b1;
                repeat (3) @(posedge clk_i);
                mon.enable_rst <= 1'b0;
                repeat (4) @(posedge clk_i);
                bus(1'b0, ADR_STATUS, 32'h0);
                cmp(q, exp_st(32'h0));
            end else clear_and_check();
        end
        // pump undervoltage ignored when disabled
        bus(1'b1, ADR_CONTROL, CTL_RESET | 32'h8);
        set_auto(1, 1'b1);
        repeat (8) @(posedge clk_i);
        cmp({oe, hiz}, 2'b00);
        set_auto(1, 1'b0);
        bus(1'b0, ADR_STATUS, 32'h0);
        cmp(q, exp_st(32'h0));
        // overcurrent: modes 0..3, mode 4 = latched with shunt disabled
        for (m = 0; m < 5; m++) for (s = 0; s < 2; s++) begin
            f = {$random(seed)} % NUM_FET;
            ctl = 32'h00090000 | ((m % 4) << CTL_MODE_LO) | ((m == 4) << CTL_SHUNT_DIS)
                  | (({$random(seed)} % 16) << CTL_VDS_LO);
            bus(1'b1, ADR_CONTROL, ctl);
            cmp(vsel, ctl[15:12]);
            @(posedge clk_i);
            if (m == 0 && s == 0) fen <= ~(6'h1 << f);
            if (s == 1) mon.shunt_over <= 1'b1;
            else mon.vds_over <= 6'h1 << f;
            if (m == 0 && s == 0) begin
                repeat (260) @(posedge clk_i);
                cmp(oe, 1'b0);
                fen <= '1;
            end
            repeat (195) @(posedge clk_i);
            cmp(oe, 1'b0);
            if (m == 3 || (m == 4 && s == 1)) begin
                repeat (70) @(posedge clk_i);
                cmp({oe, hiz}, 2'b00);
            end else begin
                wait_oe(1'b1, 20);
                cmp(hiz, m != 2);
                cmp({red, cur}, {m != 2, (m != 2) ? 4'h0 : 4'h9});
                bus(1'b0, ADR_STATUS, 32'h0);
                cmp(q, exp_st(s ? 32'h10 : (32'h8 | (32'h1 << (ST_VDS_LO + f)))));
                if (m == 0) bus(1'b1, ADR_CONTROL, ctl | 32'h1);
                mon.shunt_over <= 1'b0;
                mon.vds_over <= '0;
                if (m == 1) begin
                    wait_oe(1'b0, RC + 10);
                    bus(1'b0, ADR_STATUS, 32'h0);
                    cmp(q, exp_st(32'h0));
                end else begin
                    repeat (10) @(posedge clk_i);
                    cmp(oe, 1'b1);
                    clear_and_check();
                end
            end
        end
        // gate stuck, then thermal warning, option off and on
        for (k = 0; k < 2; k++) begin
            ctl = CTL_RESET | (k << CTL_GATE_DIS);
            bus(1'b1, ADR_CONTROL, ctl);
            mon.gate_stuck <= 6'h04;
            repeat (8) @(posedge clk_i);
            cmp({oe, hiz}, {!k, !k});
            mon.gate_stuck <= 6'h00;
            repeat (8) @(posedge clk_i);
            bus(1'b0, ADR_STATUS, 32'h0);
            cmp(q, exp_st(k ? 32'h0 : 32'h04000020));
            clear_and_check();
            bus(1'b1, ADR_CONTROL, CTL_RESET | (k << CTL_TW_REP));
            mon.thermal_warn <= 1'b1;
            repeat (8) @(posedge clk_i);
            cmp({oe, hiz}, {k[0], 1'b0});
            bus(1'b0, ADR_STATUS, 32'h0);
            cmp(q, exp_st(32'h40));
            mon.thermal_warn <= 1'b0;
            repeat (8) @(posedge clk_i);
            bus(1'b0, ADR_STATUS, 32'h0);
            cmp(oe, 1'b0);
            cmp(q, exp_st(32'h0));
        end
        finish_test(1'b0);
    end
endmodule
`default_nettype wire
